// File: design/gpio_pin_control_and_function_mux.sv
/*
 * Per-pin control and function multiplexer for the general purpose pins:
 * input sync and de-bounce, edge interrupt status, request outputs,
 * pulls and keeper, output polarity and drive type, loop clock dividers.
 * Assumes configuration, masks and sources come from logic on clk; only
 * the pad inputs are asynchronous. Pads resolve oe_n, pulls and keeper.
 */
`default_nettype none

module gpio_pin_control_and_function_mux #(
    parameter int PINS      = pin_mux_pkg::PIN_COUNT,
    parameter int DEDICATED = pin_mux_pkg::DEDICATED_PINS
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            slow_clock_enable,
    input  wire logic [pin_mux_pkg::DB_SEL_W-1:0] debounce_time_select,
    input  wire pin_mux_pkg::pin_config_t [PINS-1:0] pin_config,
    input  wire logic [PINS-1:0]                 pad_in,
    input  wire logic [PINS-1:0]                 alt_out,
    input  wire logic [PINS-1:0]                 alt_oe,
    input  wire logic [PINS-1:0]                 dsp_out,
    input  wire logic [PINS-1:0]                 dsp_direction,
    input  wire logic [PINS-1:0]                 irq_mask_one,
    input  wire logic [PINS-1:0]                 irq_mask_two,
    input  wire logic [PINS-1:0]                 irq_clear,
    input  wire logic [2:0]                      loop_tick,
    input  wire pin_mux_pkg::loop_clock_cfg_t [2:0] loop_clock,
    input  wire logic [2:0]                      loop_lock,
    output pin_mux_pkg::pad_drive_t [PINS-1:0]   pad,
    output logic [PINS-1:0]                      pin_level,
    output logic [PINS-1:0]                      irq_status,
    output logic                                 interrupt_request_one,
    output logic                                 interrupt_request_two
);
    import pin_mux_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (PINS <= DEDICATED) begin : g_bad_pins
        $error("pin count must exceed the dedicated pin count");
    end
    if (LOOP_COUNT != 3) begin : g_bad_loops
        $error("function codes cover exactly three loops");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PINS-1:0]                       sync1;
        logic [PINS-1:0]                       sync2;
        logic [PINS-1:0]                       sync3;
        logic [PINS-1:0]                       clean;
        logic [PINS-1:0]                       last_level;
        logic [PINS-1:0]                       status;
        logic [PINS-1:0]                       level_read;
        pad_drive_t [PINS-1:0]                 pad;
        logic                                  irq_one;
        logic                                  irq_two;
        logic [SLOW_W-1:0]                     slow_count;
        logic                                  slow_tick;
        logic [2:0][LOOP_DIV_W-1:0]            loop_count;
        logic [2:0]                            loop_clk;
    } state_t;

    localparam pad_drive_t PAD_RESET = '{
        out:       1'b0,
        oe_n:      OE_N_RESET,
        pull_up:   PULL_RESET,
        pull_down: PULL_RESET
    };

    state_t          st;
    state_t          next_st;
    logic [PINS-1:0] deb_level;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Codes whose pad behaviour belongs to another block
    function automatic logic fixed_drive(input logic [FN_W-1:0] fn);
        return (fn == FN_ALT) || (fn == FN_DSP);
    endfunction

    // Half period in loop ticks; zero is read as one
    function automatic logic [LOOP_DIV_W-1:0] half_period(
        input logic [LOOP_DIV_W-1:0] div
    );
        return (div == '0) ? LOOP_DIV_W'(1) : div;
    endfunction

    // ------------------------------------------------------------------
    // De-bounce stages
    // ------------------------------------------------------------------
    for (genvar i = 0; i < PINS; i++) begin : g_debounce
        pin_debounce #(
            .SEL_W (DB_SEL_W),
            .CNT_W (DB_CNT_W)
        ) u_debounce (
            .clk         (clk),
            .rstn        (rstn),
            .tick        (st.slow_tick),
            .enable      (pin_config[i].pin_debounce_enable),
            .time_select (debounce_time_select),
            .raw         (st.clean[i]),
            .level       (deb_level[i])
        );
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic                  val;
        logic                  drv;
        logic                  fixed;
        logic [LOOP_DIV_W-1:0] half;
        pin_config_t           c;
        val   = 1'b0;
        drv   = 1'b0;
        fixed = 1'b0;
        half  = '0;
        c     = '0;
        next_st = st;

        // Pad inputs are asynchronous; a change counts once two agree
        next_st.sync1 = pad_in;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.clean = (st.sync2 & st.sync3)
                      | (st.clean & (st.sync2 ^ st.sync3));

        // Edge events; a new event wins over a clear in the same cycle
        next_st.last_level = deb_level;
        next_st.status = (st.status & ~irq_clear)
                       | (deb_level ^ st.last_level);
        next_st.irq_one = |(next_st.status & ~irq_mask_one);
        next_st.irq_two = |(next_st.status & ~irq_mask_two);

        // 32 kHz tick; stops when the slow clock is off
        next_st.slow_tick = 1'b0;
        if (!slow_clock_enable) begin
            next_st.slow_count = '0;
        end else if (st.slow_count == SLOW_LAST) begin
            next_st.slow_count = '0;
            next_st.slow_tick  = 1'b1;
        end else begin
            next_st.slow_count = st.slow_count + 1'b1;
        end

        // Loop pin clocks; dividers only shape the pin, never the loop
        for (int k = 0; k < 3; k++) begin
            half = half_period(loop_clock[k].loop_pin_clock_divider);
            if (!loop_clock[k].loop_pin_clock_enable) begin
                next_st.loop_count[k] = '0;
                next_st.loop_clk[k]   = 1'b0;
            end else if (loop_tick[k]) begin
                if (st.loop_count[k] >= half - 1'b1) begin
                    next_st.loop_count[k] = '0;
                    next_st.loop_clk[k]   = ~st.loop_clk[k];
                end else begin
                    next_st.loop_count[k] = st.loop_count[k] + 1'b1;
                end
            end
        end

        // Function multiplexer, one pin at a time
        for (int i = 0; i < PINS; i++) begin
            c     = pin_config[i];
            fixed = fixed_drive(c.pin_function_select);
            drv   = !c.pin_direction;
            unique case (c.pin_function_select)
                FN_ALT: begin
                    // Dedicated pins have no alternative, so they float
                    val = alt_out[i];
                    drv = (i >= DEDICATED) && alt_oe[i];
                end
                FN_GPIO: begin
                    val = c.pin_level;
                end
                FN_DSP: begin
                    val = dsp_out[i];
                    drv = !dsp_direction[i];
                end
                FN_IRQ_ONE: begin
                    val = st.irq_one;
                end
                FN_IRQ_TWO: begin
                    val = st.irq_two;
                end
                FN_LOOP_CLK1: begin
                    val = st.loop_clk[0];
                end
                FN_LOOP_CLK2: begin
                    val = st.loop_clk[1];
                end
                FN_LOOP_CLK3: begin
                    val = st.loop_clk[2];
                end
                FN_LOCK1: begin
                    val = loop_lock[0];
                end
                FN_LOCK2: begin
                    val = loop_lock[1];
                end
                FN_LOCK3: begin
                    val = loop_lock[2];
                end
                default: begin
                    // Sources of other codes live outside; drive low
                    val = 1'b0;
                end
            endcase
            if (!fixed) begin
                val = val ^ c.pin_polarity_invert;
            end
            next_st.pad[i].out = val;
            // Open-drain releases for high so a wired-or line can rise
            next_st.pad[i].oe_n = !(drv && !(!fixed && c.pin_drive_type
                                             && val));
            next_st.pad[i].pull_up   = c.pin_pullup_enable;
            next_st.pad[i].pull_down = c.pin_pulldown_enable;
            // Write-only while driving: reads as zero then
            next_st.level_read[i] = drv ? 1'b0 : deb_level[i];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st     <= '0;
            st.pad <= {PINS{PAD_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign pad                   = st.pad;
    assign pin_level             = st.level_read;
    assign irq_status            = st.status;
    assign interrupt_request_one = st.irq_one;
    assign interrupt_request_two = st.irq_two;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    status_latched_a: assert property (
        ($past(irq_status) & ~$past(irq_clear) & ~irq_status) == '0)
        else $error("interrupt status bit dropped without a clear");

    edge_event_a: assert property (
        $changed(deb_level) |=> ((irq_status & ($past(deb_level)
            ^ $past(deb_level, 2))) == ($past(deb_level)
            ^ $past(deb_level, 2))))
        else $error("level edge did not set its status bit");

    request_one_a: assert property (
        interrupt_request_one == |(irq_status & ~$past(irq_mask_one)))
        else $error("request one disagrees with masked status");

    request_two_a: assert property (
        interrupt_request_two == |(irq_status & ~$past(irq_mask_two)))
        else $error("request two disagrees with masked status");

    tick_spacing_a: assert property (
        st.slow_tick |-> $past(st.slow_count) == SLOW_LAST
            && $past(slow_clock_enable))
        else $error("slow tick off its period");

    reset_keeper_a: assert property (
        $rose(rstn) |-> ##0 (pad[0].pull_up && pad[0].pull_down))
        else $error("keeper not active out of reset");

    for (genvar k = 0; k < 3; k++) begin : g_loop_chk
        loop_gated_a: assert property (
            !loop_clock[k].loop_pin_clock_enable |=> !st.loop_clk[k]
                ##1 !st.loop_clk[k] || $past(loop_clock[k],1) != 0)
            else $error("loop pin clock runs while disabled");
    end

    for (genvar i = 0; i < PINS; i++) begin : g_pin_chk
        level_drive_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_GPIO
            && !$past(pin_config[i].pin_direction)
            && !$past(pin_config[i].pin_drive_type) |->
                !pad[i].oe_n && pad[i].out ==
                ($past(pin_config[i].pin_level)
                 ^ $past(pin_config[i].pin_polarity_invert)))
            else $error("logic output level wrong");

        open_drain_a: assert property (
            $past(pin_config[i].pin_drive_type)
            && !fixed_drive($past(pin_config[i].pin_function_select))
            && !pad[i].oe_n |-> !pad[i].out)
            else $error("open-drain pin drives high");

        input_read_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_GPIO
            && $past(pin_config[i].pin_direction) |->
                pin_level[i] == $past(deb_level[i]) && pad[i].oe_n)
            else $error("input level read wrong");

        write_only_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_GPIO
            && !$past(pin_config[i].pin_direction) |-> !pin_level[i])
            else $error("output pin level is readable");

        dsp_dir_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_DSP |->
                pad[i].oe_n == $past(dsp_direction[i])
                && pad[i].out == $past(dsp_out[i]))
            else $error("processor pin direction not followed");

        alt_dir_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_ALT |->
                pad[i].oe_n == !((i >= DEDICATED) && $past(alt_oe[i])))
            else $error("alternative function direction not followed");

        irq_pin_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_IRQ_ONE
            && !$past(pin_config[i].pin_polarity_invert) |->
                pad[i].out == $past(interrupt_request_one))
            else $error("request one not shown on selected pin");

        lock_pin_a: assert property (
            $past(pin_config[i].pin_function_select) == FN_LOCK2
            && !$past(pin_config[i].pin_polarity_invert) |->
                pad[i].out == $past(loop_lock[1]))
            else $error("loop lock not shown on selected pin");
    end

endmodule // gpio_pin_control_and_function_mux

`default_nettype wire

// File: inc/pin_mux_pkg.sv
/*
 * Shared constants and carrier types for the general purpose pin block:
 * function codes, timing counts, per-pin configuration and pad drive.
 * Assumes one 100 MHz clock and pads that resolve oe_n and pulls.
 */
`default_nettype none

package pin_mux_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int PIN_COUNT      = 40;
    localparam int DEDICATED_PINS = 8;
    localparam int LOOP_COUNT     = 3;
    localparam int FN_W           = 9;
    localparam int DB_SEL_W       = 4;
    localparam int DB_CNT_W       = 16;
    localparam int LOOP_DIV_W     = 6;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ   = 100_000_000;
    localparam int SLOW_HZ  = 32_000;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam int SLOW_W   = $clog2(SLOW_DIV);
    localparam logic [SLOW_W-1:0] SLOW_LAST = SLOW_W'(SLOW_DIV - 1);

    // ------------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------------
    localparam logic [FN_W-1:0] FN_ALT       = 9'h000;
    localparam logic [FN_W-1:0] FN_GPIO      = 9'h001;
    localparam logic [FN_W-1:0] FN_DSP       = 9'h002;
    localparam logic [FN_W-1:0] FN_IRQ_ONE   = 9'h003;
    localparam logic [FN_W-1:0] FN_IRQ_TWO   = 9'h004;
    localparam logic [FN_W-1:0] FN_LOOP_CLK1 = 9'h010;
    localparam logic [FN_W-1:0] FN_LOOP_CLK2 = 9'h011;
    localparam logic [FN_W-1:0] FN_LOOP_CLK3 = 9'h012;
    localparam logic [FN_W-1:0] FN_LOCK1     = 9'h018;
    localparam logic [FN_W-1:0] FN_LOCK2     = 9'h019;
    localparam logic [FN_W-1:0] FN_LOCK3     = 9'h01A;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic PULL_RESET = 1'b1;
    localparam logic OE_N_RESET = 1'b1;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic            pin_debounce_enable;
        logic            pin_pullup_enable;
        logic            pin_pulldown_enable;
        logic            pin_direction;
        logic [FN_W-1:0] pin_function_select;
        logic            pin_level;
        logic            pin_polarity_invert;
        logic            pin_drive_type;
    } pin_config_t;

    typedef struct packed {
        logic out;
        logic oe_n;
        logic pull_up;
        logic pull_down;
    } pad_drive_t;

    typedef struct packed {
        logic                  loop_pin_clock_enable;
        logic [LOOP_DIV_W-1:0] loop_pin_clock_divider;
    } loop_clock_cfg_t;

endpackage

`default_nettype wire

// File: design/pin_debounce.sv
/*
 * One pin's de-bounce stage, stepped by the shared 32 kHz tick.
 * Assumes raw is already synchronised to clk.
 */
`default_nettype none

module pin_debounce #(
    parameter int SEL_W = pin_mux_pkg::DB_SEL_W,
    parameter int CNT_W = pin_mux_pkg::DB_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic [SEL_W-1:0] time_select,
    input  wire logic             raw,
    output logic                  level
);
    import pin_mux_pkg::*;

    if (CNT_W < (1 << SEL_W)) begin : g_bad_width
        $error("de-bounce counter too narrow for the time select");
    end

    typedef struct packed {
        logic             level;
        logic [CNT_W-1:0] count;
    } db_state_t;

    db_state_t st;
    db_state_t next_st;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] next_count;

    // Tick phase is unknown, so one tick more than 2**sel is counted
    function automatic logic [CNT_W-1:0] db_limit(input logic [SEL_W-1:0] s);
        return CNT_W'(1) << s;
    endfunction

    assign limit      = db_limit(time_select);
    assign next_count = st.count + 1'b1;

    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st.level = raw;
            next_st.count = '0;
        end else if (raw == st.level) begin
            next_st.count = '0;
        end else if (tick) begin
            if (next_count > limit) begin
                next_st.level = raw;
                next_st.count = '0;
            end else begin
                next_st.count = next_count;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

    stable_wait_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(enable) && $changed(level) |->
            level == $past(raw) && $past(tick)
            && $past(next_count) > $past(limit))
        else $error("de-bounced level moved before the stable time");

    bypass_follow_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !enable |=> level == $past(raw))
        else $error("de-bounce off but level does not follow input");

endmodule // pin_debounce

`default_nettype wire

// File: tb/pin_partner.sv
/* Pads plus outside devices for the pin block.
 * Assumes pad drive from the block and one outside driver per pin. */
`default_nettype none
module pin_partner (
    input  wire pin_mux_pkg::pad_drive_t [39:0] pad,
    input  wire logic [39:0]                    ext_oe,
    input  wire logic [39:0]                    ext_val,
    output var logic [39:0]                     pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;
    initial pad_in = '0;
    // Floating pins flip so a stale level never passes for valid
    always @(pad, ext_oe, ext_val) begin
        for (int i = 0; i < 40; i++) begin
            if (!pad[i].oe_n)
                pad_in[i] = pad[i].out;
            else if (ext_oe[i])
                pad_in[i] = ext_val[i];
            else if (pad[i].pull_up && pad[i].pull_down)
                pad_in[i] = pad_in[i];
            else if (pad[i].pull_up || pad[i].pull_down)
                pad_in[i] = pad[i].pull_up;
            else
                pad_in[i] = ~pad_in[i];
        end
    end
endmodule // pin_partner
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench for the pin control block.
 * Assumes the pad partner model and the shared package. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;
    logic clk = 0, rstn = 0, slow_en = 0, r1, r2;
    logic [3:0] ds = 4'h1;
    pin_config_t [39:0] cfg;
    pad_drive_t [39:0]  pad;
    logic [39:0] pad_in, alt_out, alt_oe, m1, m2, clr, ext_oe, ext_val;
    logic [39:0] lvl, st, dsp_o, dsp_d;
    logic [2:0] lock, ltick;
    loop_clock_cfg_t [2:0] lcfg;
    int failures = 0, num_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    gpio_pin_control_and_function_mux gpio_pin_control_and_function_mux_i (
        .clk(clk), .rstn(rstn), .slow_clock_enable(slow_en),
        .debounce_time_select(ds), .pin_config(cfg), .pad_in(pad_in),
        .alt_out(alt_out), .alt_oe(alt_oe), .dsp_out(dsp_o),
        .dsp_direction(dsp_d), .irq_mask_one(m1), .irq_mask_two(m2),
        .irq_clear(clr), .loop_tick(ltick), .loop_clock(lcfg),
        .loop_lock(lock), .pad(pad), .pin_level(lvl), .irq_status(st),
        .interrupt_request_one(r1), .interrupt_request_two(r2));
    pin_partner pin_partner_i (.pad(pad), .ext_oe(ext_oe),
        .ext_val(ext_val), .pad_in(pad_in));
    task automatic chk(input string what, input logic [3:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set(input int i, input logic db, dir,
            input logic [FN_W-1:0] fn, input logic lv, pol, dt);
        @(posedge clk) cfg[i] <= '{db, 1'b1, 1'b1, dir, fn, lv, pol, dt};
        tick(1);
    endtask
    task automatic t_output;
        set(0, 0, 0, FN_GPIO, 1, 0, 0);
        chk("drive", {pad[0].out, pad[0].oe_n, lvl[0], 1'b0}, 4'h8);
        set(0, 0, 0, FN_GPIO, 1, 1, 0);
        chk("invert", {pad[0].out, pad[0].oe_n, 2'b00}, 4'h0);
        set(0, 0, 0, FN_GPIO, 0, 0, 1);
        chk("drain low", {pad[0].out, pad[0].oe_n, 2'b00}, 4'h0);
        set(0, 0, 0, FN_GPIO, 1, 0, 1);
        chk("drain high", {3'b000, pad[0].oe_n}, 4'h1);
        set(0, 0, 0, FN_ALT, 1, 0, 0);
        chk("dedicated", {3'b000, pad[0].oe_n}, 4'h1);
    endtask
    task automatic t_input;
        set(1, 0, 1, FN_GPIO, 0, 1, 0);
        @(posedge clk) ext_val[1] <= 1'b1;
        tick(6);
        chk("rise", {lvl[1], st[1], r1, r2}, 4'hE);
        @(posedge clk) clr[1] <= 1'b1;
        @(posedge clk) clr[1] <= 1'b0;
        tick(1);
        chk("clear", {3'b000, st[1]}, 4'h0);
        @(posedge clk) ext_val[1] <= 1'b0;
        tick(25);
        chk("fall", {lvl[1], st[1], r1, 1'b0}, 4'h6);
    endtask
    task automatic t_debounce;
        int n;
        set(2, 1, 1, FN_GPIO, 0, 0, 0);
        @(posedge clk) slow_en <= 1'b1;
        @(posedge clk) ext_val[2] <= 1'b1;
        tick(6200);
        chk("held", {3'b000, lvl[2]}, 4'h0);
        for (n = 0; n < 10000 && lvl[2] !== 1'b1; n++) tick(1);
        chk("settled", {3'b000, lvl[2]}, 4'h1);
        @(posedge clk) slow_en <= 1'b0;
        ext_val[2] <= 1'b0;
        tick(10000);
        chk("frozen", {3'b000, lvl[2]}, 4'h1);
    endtask
    task automatic t_mux;
        set(8, 0, 0, FN_IRQ_ONE, 0, 0, 0);
        chk("req one", {3'b000, pad[8].out}, 4'h1);
        set(8, 0, 0, FN_IRQ_TWO, 0, 0, 0);
        chk("req two", {3'b000, pad[8].out}, 4'h0);
        for (int n = 0; n < 3; n++) begin
            set(8, 0, 0, FN_W'(FN_LOCK1 + n), 0, 0, 0);
            chk("lock", {3'b000, pad[8].out}, {3'b000, lock[n]});
        end
        set(8, 0, 1, FN_ALT, 0, 1, 1);
        chk("alt", {pad[8].out, pad[8].oe_n, 2'b00}, 4'h8);
    endtask
    task automatic t_pull;
        @(posedge clk) begin
            cfg[3].pin_pulldown_enable <= 1'b0;
            ext_oe[3] <= 1'b0;
        end
        tick(8);
        chk("pull", {2'b00, pad[3].pull_down, lvl[3]}, 4'h1);
        @(posedge clk) cfg[3].pin_pulldown_enable <= 1'b1;
        tick(8);
        chk("keeper", {2'b00, pad[3].pull_down, lvl[3]}, 4'h3);
    endtask
    task automatic t_dsp;
        set(9, 0, 1, FN_DSP, 0, 1, 1);
        chk("dsp", {pad[9].out, pad[9].oe_n, 2'b00}, 4'h8);
        @(posedge clk) dsp_d[9] <= 1'b1;
        tick(1);
        chk("dsp in", {3'b000, pad[9].oe_n}, 4'h1);
    endtask
    task automatic t_loop;
        set(10, 0, 0, FN_LOOP_CLK1, 0, 0, 0);
        @(posedge clk) lcfg[0].loop_pin_clock_divider <= 6'h02;
        @(posedge clk) lcfg[0].loop_pin_clock_enable <= 1'b1;
        for (int n = 0; n < 3; n++) begin
            @(posedge clk) ltick <= 3'h1;
            @(posedge clk) ltick <= 3'h0;
            tick(1);
            chk("loop clk", {3'b000, pad[10].out}, {3'b000, n != 0});
        end
        @(posedge clk) lcfg[0].loop_pin_clock_enable <= 1'b0;
        tick(2);
        chk("loop off", {3'b000, pad[10].out}, 4'h0);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        for (int i = 0; i < 40; i++)
            cfg[i] = '{1'b0, 1'b1, 1'b1, 1'b1, FN_GPIO, 1'b0, 1'b0, 1'b0};
        alt_out = 40'h00_0000_0100;
        alt_oe = 40'h00_0000_0100;
        dsp_o = 40'h00_0000_0200;
        dsp_d = '0;
        ltick = '0;
        lcfg = '0;
        m1 = '0;
        m2 = '1;
        clr = '0;
        ext_oe = '1;
        ext_val = '0;
        lock = 3'h2;
        repeat (10) @(posedge clk);
        chk("reset pad", pad[0], 4'h7);
        rstn <= 1'b1;
        t_output;
        t_input;
        t_debounce;
        t_mux;
        t_pull;
        t_dsp;
        t_loop;
        end_sim;
    end
endmodule // testbench
`default_nettype wire
